// ---- design/dtmc_pkg.sv ----
// constants, types and carriers shared by the temperature monitor core
// Notes on behaviour
// - conversions repeat without any host command
// - local channel then remote channel, alternating
// - results stored as 8-bit two's complement
// - four limits: local/remote high and low
// - compare after each result, set status flags
// - alert pulled low from any trip until acknowledged
// - alert pin is open-drain: pull low or release
// - standby pin low stops conversions
// - slave address from two three-state straps
// - host writes limits, reads every register
// - host sets standby, alert mask, rate
// - each result averages 16 raw measurements
// - one degree per lsb, -128 to +127
// - busy bit 7, five flags, OR sets latch
// - status read clears flags no longer tripped
// - config bit7 masks alert, bit6 standby, reset 0
// - rate code divides clock 1..128, 125ms..16s
package dtmc_pkg;
   // =====================================================
   // timing
   localparam int CLK_HZ         = 20_000_000;
   localparam int CONV_PERIOD_MS = 125;
   localparam int CONV_BASE_CYC  = CLK_HZ / 1000 * CONV_PERIOD_MS;
   localparam int AVG_COUNT      = 16;
   localparam int RATE_MAX       = 7;
   // =====================================================
   // register indices (byte address = 4 * index)
   localparam logic [7:0] RD_LOCAL   = 8'h00;
   localparam logic [7:0] RD_REMOTE  = 8'h01;
   localparam logic [7:0] RD_STATUS  = 8'h02;
   localparam logic [7:0] RD_CFG     = 8'h03;
   localparam logic [7:0] RD_RATE    = 8'h04;
   localparam logic [7:0] RD_LHI     = 8'h05;
   localparam logic [7:0] RD_LLO     = 8'h06;
   localparam logic [7:0] RD_RHI     = 8'h07;
   localparam logic [7:0] RD_RLO     = 8'h08;
   localparam logic [7:0] WR_CFG     = 8'h09;
   localparam logic [7:0] WR_RATE    = 8'h0a;
   localparam logic [7:0] WR_LHI     = 8'h0b;
   localparam logic [7:0] WR_LLO     = 8'h0c;
   localparam logic [7:0] WR_RHI     = 8'h0d;
   localparam logic [7:0] WR_RLO     = 8'h0e;
   localparam logic [7:0] WR_ONESHOT = 8'h0f;
   localparam logic [7:0] RW_IRQ_ST  = 8'h20;
   localparam logic [7:0] WR_IRQ_CLR = 8'h21;
   localparam logic [7:0] RW_IRQ_EN  = 8'h22;
   localparam logic [7:0] WR_ALERT_ACK = 8'h23;
   localparam logic [7:0] RD_SLV_ADDR  = 8'h24;
   localparam logic [7:0] RD_DEV_ID  = 8'hfe;
   localparam logic [7:0] RD_REV     = 8'hff;
   // =====================================================
   // field positions
   localparam int CFG_MASK_BIT    = 7;
   localparam int CFG_STANDBY_BIT = 6;
   localparam int ST_BUSY = 7;
   localparam int ST_LHI  = 6;
   localparam int ST_LLO  = 5;
   localparam int ST_RHI  = 4;
   localparam int ST_RLO  = 3;
   localparam int ST_OPEN = 2;
   localparam int IRQ_CONV  = 0;
   localparam int IRQ_FAULT = 1;
   localparam int IRQ_W     = 2;
   // =====================================================
   // reset values
   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam logic [7:0] RATE_RST = 8'h02;
   localparam logic [7:0] HI_RST   = 8'h7f;
   localparam logic [7:0] LO_RST   = 8'hc9;
   // arbitrary values, not those of any real part
   localparam logic [7:0] DEV_ID_VAL = 8'h5a;
   localparam logic [7:0] REV_VAL    = 8'h01;
   localparam logic [6:0] SLV_BASE   = 7'h10;
   // =====================================================
   // types
   typedef enum logic [1:0] {
      STRAP_LOW   = 2'h0,
      STRAP_FLOAT = 2'h1,
      STRAP_HIGH  = 2'h2
   } dtmc_strap_t;

   typedef struct packed {
      logic signed [7:0] data;
      logic              open;
   } dtmc_adc_res_t;
endpackage

// ---- design/dtmc_sync.sv ----
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module dtmc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   if (W < 1) begin : g_chk
      $error("dtmc_sync: width must be at least 1");
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end

   assign q_o = q_ff;
endmodule

// ---- design/dtmc_avg.sv ----
// running sum of raw samples, emits the mean of each group
`timescale 1ns/100ps
module dtmc_avg #(
   parameter int N = 16
) (
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   input  wire logic              clr_i,
   input  wire logic              add_i,
   input  wire logic signed [7:0] sample_i,
   output logic                   last_o,
   output logic signed [7:0]      mean_o
);
   localparam int SH = $clog2(N);
   localparam int SW = 8 + SH;

   logic signed [SW-1:0] sum_ff;
   logic [SH-1:0]        cnt_ff;
   logic signed [SW-1:0] nxt_sum;
   logic signed [7:0]    mean_ff;

   // mean is a plain shift, so only powers of two are served
   if (N < 2 || (1 << SH) != N) begin : g_chk
      $error("dtmc_avg: N must be a power of two, at least 2");
   end

   assign nxt_sum = sum_ff + SW'(sample_i);
   assign last_o  = (cnt_ff == SH'(N - 1));

   always_ff @(posedge clk_i) begin
      if (srst_i || clr_i) begin
         sum_ff <= '0;
         cnt_ff <= '0;
      end else if (add_i) begin
         sum_ff <= last_o ? '0 : nxt_sum;
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mean_ff <= '0;
      end else if (add_i && last_o) begin
         mean_ff <= 8'(nxt_sum >>> SH);
      end
   end

   assign mean_o = mean_ff;
endmodule

// ---- design/dtmc_core.sv ----
// two-channel temperature monitor core with Avalon-MM register slave
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module dtmc_core
   import dtmc_pkg::*;
#(
   parameter int P_BASE_CYC = dtmc_pkg::CONV_BASE_CYC
) (
   input  wire logic                    clk_i,
   input  wire logic                    srst_i,
   input  wire logic [9:0]              avs_address_i,
   input  wire logic                    avs_read_i,
   input  wire logic                    avs_write_i,
   input  wire logic [31:0]             avs_writedata_i,
   output logic      [31:0]             avs_readdata_o,
   output logic                         avs_waitrequest_o,
   output logic                         adc_start_o,
   output logic                         adc_chan_o,
   input  wire logic                    adc_done_i,
   input  wire dtmc_pkg::dtmc_adc_res_t adc_res_i,
   input  wire logic                    standby_pin_n_i,
   input  wire dtmc_pkg::dtmc_strap_t   addr_strap_high_i,
   input  wire dtmc_pkg::dtmc_strap_t   addr_strap_low_i,
   output logic                         alert_o,
   output logic                         alert_oe_n_o,
   output logic [6:0]                   slv_addr_o,
   output logic                         busy_o,
   output logic                         irq_o
);
   import dtmc_pkg::*;

   if (P_BASE_CYC < 1) begin : g_chk
      $error("dtmc_core: P_BASE_CYC must be at least 1");
   end

   // =====================================================
   // helpers
   // two bits: {above high, below low}, signed lsb = 1 degree
   function automatic logic [1:0] out_of(input logic [7:0] v,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
      out_of = {$signed(v) > $signed(hi), $signed(v) < $signed(lo)};
   endfunction

   function automatic logic [6:0] strap_val(input dtmc_strap_t s);
      unique case (s)
         STRAP_LOW:   strap_val = 7'h0;
         STRAP_FLOAT: strap_val = 7'h1;
         STRAP_HIGH:  strap_val = 7'h2;
         default:     strap_val = 7'h1;
      endcase
   endfunction

   // =====================================================
   // pin synchronisers
   logic       standby_n_s;
   logic [1:0] strap_hi_s;
   logic [1:0] strap_lo_s;

   dtmc_sync #(.W(5)) u_sync (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .d_i    ({standby_pin_n_i, addr_strap_high_i, addr_strap_low_i}),
      .q_o    ({standby_n_s, strap_hi_s, strap_lo_s})
   );

   // =====================================================
   // registers
   logic [7:0]       cfg_ff;
   logic [7:0]       rate_ff;
   logic [7:0]       lhi_ff;
   logic [7:0]       llo_ff;
   logic [7:0]       rhi_ff;
   logic [7:0]       rlo_ff;
   logic [7:0]       local_ff;
   logic [7:0]       remote_ff;
   logic             open_ff;
   logic [4:0]       flags_ff;
   logic             alert_latch_ff;
   logic [IRQ_W-1:0] irq_st_ff;
   logic [IRQ_W-1:0] irq_en_ff;
   logic [6:0]       slv_addr_ff;
   logic [2:0]       strap_wait_ff;
   logic             ack_ff;
   logic [31:0]      rdata_ff;

   // =====================================================
   // bus decode: one wait cycle, then the answer
   logic       req;
   logic       do_wr;
   logic       do_rd;
   logic [7:0] idx;
   logic [7:0] wdat;

   assign req   = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_ff;
   assign do_wr = avs_write_i & ack_ff;
   assign do_rd = avs_read_i & ack_ff;
   assign idx   = avs_address_i[9:2];
   assign wdat  = avs_writedata_i[7:0];

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   // =====================================================
   // host configuration
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cfg_ff    <= CFG_RST;
         rate_ff   <= RATE_RST;
         lhi_ff    <= HI_RST;
         llo_ff    <= LO_RST;
         rhi_ff    <= HI_RST;
         rlo_ff    <= LO_RST;
         irq_en_ff <= '0;
      end else if (do_wr) begin
         unique case (idx)
            WR_CFG:    cfg_ff    <= wdat & 8'hc0;
            WR_RATE:   rate_ff   <= wdat & 8'h07;
            WR_LHI:    lhi_ff    <= wdat;
            WR_LLO:    llo_ff    <= wdat;
            WR_RHI:    rhi_ff    <= wdat;
            WR_RLO:    rlo_ff    <= wdat;
            RW_IRQ_EN: irq_en_ff <= avs_writedata_i[IRQ_W-1:0];
            default:   ;
         endcase
      end
   end

   // =====================================================
   // slave address, caught once the synchronisers have filled
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         strap_wait_ff <= 3'h0;
         slv_addr_ff   <= SLV_BASE;
      end else if (strap_wait_ff != 3'h3) begin
         strap_wait_ff <= strap_wait_ff + 3'h1;
         if (strap_wait_ff == 3'h2) begin
            slv_addr_ff <= SLV_BASE + 7'(3 * strap_val(dtmc_strap_t'(strap_hi_s)))
                         + strap_val(dtmc_strap_t'(strap_lo_s));
         end
      end
   end

   assign slv_addr_o = slv_addr_ff;

   // =====================================================
   // conversion period: base tick, then power-of-two prescale
   logic        run;
   logic        oneshot_ff;
   logic        pend_ff;
   logic [31:0] base_cnt_ff;
   logic [7:0]  pre_cnt_ff;
   logic        base_tick;
   logic [7:0]  pre_top;
   logic        start;

   // standby from pin or config; a stopped core still serves the bus
   assign run       = standby_n_s & ~cfg_ff[CFG_STANDBY_BIT];
   assign base_tick = (base_cnt_ff == 32'(P_BASE_CYC - 1));
   assign pre_top   = 8'((9'h1 << (3'(RATE_MAX) - rate_ff[2:0])) - 9'h1);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         base_cnt_ff <= '0;
         pre_cnt_ff  <= '0;
      end else begin
         base_cnt_ff <= base_tick ? '0 : base_cnt_ff + 32'h1;
         if (base_tick) begin
            pre_cnt_ff <= (pre_cnt_ff >= pre_top) ? 8'h0 : pre_cnt_ff + 8'h1;
         end
      end
   end

   // =====================================================
   // sequencer
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_REQ   = 4'b0010,
      S_WAIT  = 4'b0100,
      S_STORE = 4'b1000
   } dtmc_state_t;

   dtmc_state_t state_ff;
   logic        chan_ff;
   logic        open_seen_ff;
   logic        avg_last;
   logic [7:0]  avg_mean;
   logic        active;
   logic        store_ev;

   assign active   = run | oneshot_ff;
   assign start    = (state_ff == S_IDLE) & (pend_ff | oneshot_ff) & active;
   assign store_ev = (state_ff == S_STORE);

   // a new period request is kept until taken or until standby (set wins)
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pend_ff <= 1'b0;
      end else if (base_tick && pre_cnt_ff >= pre_top && run) begin
         pend_ff <= 1'b1;
      end else if (start || !run) begin
         pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         oneshot_ff <= 1'b0;
      end else if (do_wr && idx == WR_ONESHOT) begin
         oneshot_ff <= 1'b1;
      end else if (state_ff == S_STORE && chan_ff) begin
         oneshot_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_ff <= S_IDLE;
         chan_ff  <= 1'b0;
      end else if (!active) begin
         state_ff <= S_IDLE;
         chan_ff  <= 1'b0;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               if (start) begin
                  state_ff <= S_REQ;
                  chan_ff  <= 1'b0;
               end
            end
            S_REQ: state_ff <= S_WAIT;
            S_WAIT: begin
               if (adc_done_i) begin
                  state_ff <= avg_last ? S_STORE : S_REQ;
               end
            end
            S_STORE: begin
               chan_ff  <= ~chan_ff;
               state_ff <= chan_ff ? S_IDLE : S_REQ;
            end
         endcase
      end
   end

   assign adc_start_o = (state_ff == S_REQ);
   assign adc_chan_o  = chan_ff;
   assign busy_o      = (state_ff != S_IDLE);

   dtmc_avg #(.N(AVG_COUNT)) u_avg (
      .clk_i    (clk_i),
      .srst_i   (srst_i),
      .clr_i    (!active || start),
      .add_i    ((state_ff == S_WAIT) & adc_done_i),
      .sample_i (adc_res_i.data),
      .last_o   (avg_last),
      .mean_o   (avg_mean)
   );

   // open sensor seen on any remote sample of this group
   always_ff @(posedge clk_i) begin
      if (srst_i || start || store_ev) begin
         open_seen_ff <= 1'b0;
      end else if (state_ff == S_WAIT && adc_done_i && chan_ff && adc_res_i.open) begin
         open_seen_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         local_ff  <= 8'h00;
         remote_ff <= 8'h00;
         open_ff   <= 1'b0;
      end else if (store_ev) begin
         if (chan_ff) begin
            remote_ff <= avg_mean;
            open_ff   <= open_seen_ff;
         end else begin
            local_ff  <= avg_mean;
         end
      end
   end

   // =====================================================
   // limit flags and alert latch
   logic [4:0] live;
   logic [4:0] set_ev;
   logic       st_read;

   // live trip state of the stored values, order lhi llo rhi rlo open
   assign live    = {out_of(local_ff, lhi_ff, llo_ff),
                     out_of(remote_ff, rhi_ff, rlo_ff), open_ff};
   assign st_read = do_rd & (idx == RD_STATUS);
   // compare against the value being stored this cycle
   assign set_ev  = !store_ev ? 5'h00 :
                    chan_ff   ? {2'b00, out_of(avg_mean, rhi_ff, rlo_ff), open_seen_ff} :
                                {out_of(avg_mean, lhi_ff, llo_ff), 3'b000};

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         flags_ff <= 5'h00;
      end else if (st_read) begin
         flags_ff <= (flags_ff & live) | set_ev;
      end else begin
         flags_ff <= flags_ff | set_ev;
      end
   end

   // cleared only by an acknowledge once every flag is gone
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         alert_latch_ff <= 1'b0;
      end else if (|flags_ff || |set_ev) begin
         alert_latch_ff <= 1'b1;
      end else if (do_wr && idx == WR_ALERT_ACK) begin
         alert_latch_ff <= 1'b0;
      end
   end

   // pin only ever pulled low or released
   assign alert_o      = 1'b0;
   assign alert_oe_n_o = ~(alert_latch_ff & ~cfg_ff[CFG_MASK_BIT]);

   // =====================================================
   // interrupt status, write-one-to-clear, set wins
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   assign irq_set = {|(set_ev & ~flags_ff), store_ev & chan_ff};
   assign irq_clr = (do_wr && idx == WR_IRQ_CLR) ? avs_writedata_i[IRQ_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_st_ff <= '0;
      end else begin
         irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set;
      end
   end

   assign irq_o = |(irq_st_ff & irq_en_ff);

   // =====================================================
   // read data, latched in the wait cycle
   logic [7:0] status;

   assign status = {busy_o, flags_ff, 2'b00};

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_ff <= '0;
      end else if (avs_read_i && !ack_ff) begin
         rdata_ff <= '0;
         unique case (idx)
            RD_LOCAL:    rdata_ff[7:0] <= local_ff;
            RD_REMOTE:   rdata_ff[7:0] <= remote_ff;
            RD_STATUS:   rdata_ff[7:0] <= status;
            RD_CFG:      rdata_ff[7:0] <= cfg_ff;
            RD_RATE:     rdata_ff[7:0] <= rate_ff;
            RD_LHI:      rdata_ff[7:0] <= lhi_ff;
            RD_LLO:      rdata_ff[7:0] <= llo_ff;
            RD_RHI:      rdata_ff[7:0] <= rhi_ff;
            RD_RLO:      rdata_ff[7:0] <= rlo_ff;
            RW_IRQ_ST:   rdata_ff[IRQ_W-1:0] <= irq_st_ff;
            RW_IRQ_EN:   rdata_ff[IRQ_W-1:0] <= irq_en_ff;
            RD_SLV_ADDR: rdata_ff[6:0] <= slv_addr_ff;
            RD_DEV_ID:   rdata_ff[7:0] <= DEV_ID_VAL;
            RD_REV:      rdata_ff[7:0] <= REV_VAL;
            default:     ;
         endcase
      end
   end

   assign avs_readdata_o = rdata_ff;
endmodule

// ---- bench/dtmc_core_props.sv ----
// concurrent checks on the temperature monitor core ports
`timescale 1ns/100ps
module dtmc_core_props (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic adc_start_o,
   input wire logic standby_pin_n_i,
   input wire logic alert_o,
   input wire logic alert_oe_n_o,
   input wire logic busy_o,
   input wire logic irq_o
);
   // =====
   // properties
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   property p_drain; alert_o == 1'b0; endproperty
   a_drain: assert property (p_drain) else $error("alert data driven high");
   property p_wait; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1
      !avs_waitrequest_o; endproperty
   a_wait: assert property (p_wait) else $error("bad wait cycle");
   property p_pulse; adc_start_o |=> !adc_start_o; endproperty
   a_pulse: assert property (p_pulse) else $error("start too long");
   property p_busy; adc_start_o |-> busy_o; endproperty
   a_busy: assert property (p_busy) else $error("start while idle");
   property p_standby; !standby_pin_n_i [*4] |-> !adc_start_o && !busy_o; endproperty
   a_standby: assert property (p_standby) else $error("converting in standby");
   // latch registers on the store edge together with the flags; busy and write are checked one and two cycles back
   property p_alert_on; $fell(alert_oe_n_o) |-> $past(busy_o) || $past(busy_o, 2) ||
      $past(avs_write_i) || $past(avs_write_i, 2); endproperty
   a_alert_on: assert property (p_alert_on) else $error("alert without cause");
   property p_alert_off; $rose(alert_oe_n_o) |-> $past(avs_write_i) ||
      $past(avs_write_i, 2); endproperty
   a_alert_off: assert property (p_alert_off) else $error("alert freed alone");
   property p_irq; $rose(irq_o) |-> $past(busy_o) || $past(avs_write_i); endproperty
   a_irq: assert property (p_irq) else $error("irq without cause");
endmodule

// ---- bench/dtmc_adc_model.sv ----
// behavioural sensor front end answering sample requests
`timescale 1ns/100ps
module dtmc_adc_model
   import dtmc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              start_i,
   input  wire logic              chan_i,
   input  wire logic [7:0]        loc_i,
   input  wire logic [7:0]        rem_i,
   input  wire logic              open_i,
   input  wire logic [2:0]        lag_i,
   output logic                   done_o,
   output dtmc_pkg::dtmc_adc_res_t res_o
);
   logic [3:0] k_ff = '0;
   logic [2:0] wait_ff = '0;
   logic       pend_ff = 1'b0;
   logic [7:0] junk_ff = 8'h5a;
   logic [7:0] v;
   assign v = chan_i ? rem_i : loc_i;
   // one high sample per 16 so only a true 16-average gives v
   always @(posedge clk_i) begin
      junk_ff <= junk_ff + 8'h35;
      done_o <= 1'b0;
      res_o <= {junk_ff, junk_ff[0]};
      if (start_i) begin
         pend_ff <= 1'b1;
         wait_ff <= lag_i;
      end else if (pend_ff && wait_ff != 3'h0) begin
         wait_ff <= wait_ff - 3'h1;
      end else if (pend_ff) begin
         pend_ff <= 1'b0;
         done_o <= 1'b1;
         k_ff <= k_ff + 4'h1;
         res_o <= {(k_ff == 4'h0) ? v + 8'h0f : v - 8'h01, chan_i & open_i};
      end
   end
endmodule

// ---- bench/dtmc_core_test.sv ----
// self-checking bench for the temperature monitor core
`timescale 1ns/100ps
module dtmc_core_test;
   import dtmc_pkg::*;
   // =====
   // signals
   logic          clk_i = 1'b0;
   logic          srst_i = 1'b1;
   logic          rd = 1'b0, wr = 1'b0, standby_n = 1'b1, opn = 1'b0;
   logic [9:0]    addr = '0;
   logic [31:0]   wdata = '0, rdata;
   logic [7:0]    loc = 8'h10, rem = 8'h20, lim [4];
   logic [2:0]    lag = 3'h6;
   logic [15:0]   seed = 16'hf62b;
   logic          start, chan, done, alert, oe_n, busy, irq, wreq;
   logic [6:0]    slv;
   dtmc_strap_t   sh = STRAP_LOW, sl = STRAP_HIGH;
   dtmc_adc_res_t res;
   int            err_count = 0, tests_run = 0;
   always #25 clk_i = ~clk_i;
   dtmc_core #(.P_BASE_CYC(20)) uut (
      .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .adc_start_o(start), .adc_chan_o(chan),
      .adc_done_i(done), .adc_res_i(res), .standby_pin_n_i(standby_n),
      .addr_strap_high_i(sh), .addr_strap_low_i(sl), .alert_o(alert),
      .alert_oe_n_o(oe_n), .slv_addr_o(slv), .busy_o(busy), .irq_o(irq));
   dtmc_adc_model u_adc (
      .clk_i(clk_i), .start_i(start), .chan_i(chan), .loc_i(loc), .rem_i(rem),
      .open_i(opn), .lag_i(lag), .done_o(done), .res_o(res));
   // =====
   // helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic rnd(output logic [7:0] r);
      seed = lfsr(seed);
      r = seed[7:0];
   endtask
   function automatic logic [7:0] clampv(input logic [7:0] r);
      if (r == 8'h80) return 8'h81;
      return ($signed(r) > 112) ? r - 8'd20 : r;
   endfunction
   function automatic logic [7:0] st_exp(input logic [7:0] l, r, input logic o);
      return {1'b0, $signed(l) > $signed(lim[0]), $signed(l) < $signed(lim[1]),
              $signed(r) > $signed(lim[2]), $signed(r) < $signed(lim[3]), o, 2'b00};
   endfunction
   // called right after a rising edge; waitrequest and read data taken at the edge
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      rd <= !w;
      wr <= w;
      addr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      q = rdata[7:0];
      chk({7'h0, wreq === 1'b0}, 8'h01);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask
   task automatic rreg(input logic [7:0] idx, output logic [7:0] q);
      bus(1'b0, idx, 8'h00, q);
   endtask
   task automatic pins(output logic [7:0] p);
      @(negedge clk_i);
      p = {4'h0, busy, alert, oe_n, irq};
      @(posedge clk_i);
   endtask
   task automatic wait_pair(input logic en);
      logic [7:0] q;
      logic [7:0] p;
      int         n;
      q = '0;
      n = 0;
      while (q[IRQ_CONV] !== 1'b1 && n < 3000) begin
         rreg(RW_IRQ_ST, q);
         n++;
      end
      pins(p);
      chk({6'h0, q[IRQ_CONV], p[0]}, {6'h0, 1'b1, en});
      wreg(WR_IRQ_CLR, 8'h03);
      pins(p);
      chk({7'h0, p[0]}, 8'h00);
   endtask
   task automatic end_sim;
      if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_i);
      err_count++;
      end_sim;
   end
   // =====
   // main sequence
   initial begin
      logic [7:0] q, p, e, m, lv, rv;
      logic [7:0] rst_v [9];
      rst_v = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rst_v[i]) begin
         rreg(8'(i), q);
         chk(q & ((i == 2) ? 8'h7f : 8'hff), rst_v[i]);
      end
      rreg(RD_SLV_ADDR, q);
      chk(q, {1'b0, SLV_BASE} + 8'h02);
      chk({1'b0, slv}, {1'b0, SLV_BASE} + 8'h02);
      wreg(8'h31, 8'hff);
      rreg(8'h30, q);
      chk(q, 8'h00);
      wreg(WR_RATE, 8'h07);
      rreg(RD_RATE, q);
      chk(q, 8'h07);
      for (int i = 0; i < 7; i++) begin
         rnd(lv);
         rnd(rv);
         lv = (i == 1) ? 8'h81 : clampv(lv);
         rv = (i == 1) ? 8'h70 : clampv(rv);
         foreach (lim[j]) rnd(lim[j]);
         if (i == 0) lim = '{lv, lv, rv, rv};
         if (i == 1) lim = '{8'h7f, 8'h80, 8'h6f, 8'hc9};
         rnd(q);
         loc <= lv;
         rem <= rv;
         opn <= (i == 2);
         lag <= q[6:4];
         sh <= dtmc_strap_t'(q[1:0]);
         sl <= dtmc_strap_t'(q[3:2]);
         for (int j = 0; j < 4; j++) wreg(WR_LHI + 8'(j), lim[j]);
         for (int j = 0; j < 4; j++) begin
            rreg(RD_LHI + 8'(j), p);
            chk(p, lim[j]);
         end
         wreg(WR_CFG, {q[7], 7'h0});
         wreg(RW_IRQ_EN, {7'h0, i[0]});
         // first pair may mix old and new samples
         repeat (3) wait_pair(i[0]);
         rreg(RD_LOCAL, p);
         chk(p, lv);
         rreg(RD_REMOTE, p);
         chk(p, rv);
         e = st_exp(lv, rv, (i == 2));
         m = 8'h7c;
         rreg(RD_STATUS, p);
         rreg(RD_STATUS, p);
         chk(p & m, e & m);
         wreg(WR_ALERT_ACK, 8'h00);
         pins(p);
         chk({7'h0, p[1]}, {7'h0, (e == 8'h00) | q[7]});
      end
      standby_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      loc <= 8'h05;
      repeat (600) @(posedge clk_i);
      pins(p);
      chk(p & 8'h08, 8'h00);
      standby_n <= 1'b1;
      wreg(WR_CFG, 8'h40);
      repeat (600) @(posedge clk_i);
      rreg(RD_LOCAL, q);
      chk(q, lv);
      // a single pair runs even while standby is selected
      wreg(WR_ONESHOT, 8'h00);
      wait_pair(1'b0);
      rreg(RD_LOCAL, q);
      chk(q, 8'h05);
      pins(p);
      chk(p & 8'h08, 8'h00);
      wreg(WR_CFG, 8'h00);
      repeat (2) wait_pair(1'b0);
      rreg(RD_LOCAL, q);
      chk(q, 8'h05);
      end_sim;
   end
endmodule
bind dtmc_core dtmc_core_props u_props (.*);
